// >>> logic/kms_scanner.sv
// Keypad matrix scanner with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Time everything from a 1 kHz tick
// - Tick runs only with keypad clock enable
// - Size register limits active columns, rows
// - Auto scanning only when scan enable set
// - Waiting: all columns low, watch rows
// - Debounce first low, recheck before scanning
// - Debounce 4 to 1024 ms, 4 ms steps
// - Low gone after debounce: back waiting
// - One column low at a time, all rows
// - Row check interval 1 to 4 ms
// - Exactly one key valid, more report nothing
// - Column order programmable, row order fixed
// - Valid key stores column, row; interrupt
// - Results change only on a valid key or a bypass column write
// - Scanning never waits for firmware
// - Wait release, debounce, restart on press
// - Release confirmed: all low, wait again
// - Scan disabled: columns show column register
// - Mid-scan disable keeps column register value
// - Bypass: firmware writes columns, reads rows
module kms_scanner
	import kms_pkg::*;
#(
	parameter int NROWS = 6,
	parameter int DIV = TICK_DIV
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [NCOL-1:0] col_drive_n,
	input wire logic [NROWS-1:0] row_sense_n,
	output logic key_irq
);
	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (NROWS < 1 || NROWS > 8 || DIV < 2) begin : g_chk_param
		$error("NROWS must lie in 1..8 and DIV be at least 2");
	end
	localparam int DW = $clog2(DIV);
	// ************************************************************
	// Registers
	// ************************************************************
	logic kce_r; // Keypad clock enable
	logic sen_r; // Auto scan enable
	logic mlt_r; // Last scan had several keys
	logic [2:0] szc_r; // Active columns minus one
	logic [2:0] szr_r; // Active rows minus one
	logic [9:0] time_r; // Debounce and row check fields
	logic [ORDL_W-1:0] ordl_r; // Column order low
	logic [ORDH_W-1:0] ordh_r; // Column order high
	logic [NCOL-1:0] col_r; // Column result
	logic [NROWS-1:0] row_r; // Row result
	logic [31:0] rdata_nxt; // Read mux
	logic wr_go; // Write takes effect this edge
	logic wstb_col; // Firmware write to column register

	// ************************************************************
	// Scanner state
	// ************************************************************
	kms_state_t st_r;
	logic [DW-1:0] div_r; // Tick divider
	logic tick_r; // One cycle keypad tick
	logic [9:0] ivl_r; // Interval counter in ticks
	logic [2:0] slot_r; // Column order slot
	logic [2:0] rowi_r; // Row being checked
	logic [1:0] hits_r; // Keys found, saturates at two
	logic [NCOL-1:0] cpat_r; // Candidate column pattern
	logic [NROWS-1:0] rpat_r; // Candidate row pattern

	// ************************************************************
	// Derived values
	// ************************************************************
	logic [2:0] ncol_m1; // Clamped active columns minus one
	logic [2:0] nrow_m1; // Clamped active rows minus one
	logic [NROWS-1:0] rmask; // Active row mask
	logic any_low; // Some active row is low
	logic [10:0] db_ticks; // Debounce ticks, 1024 needs 11 bits
	logic [10:0] rc_ticks; // Row check length in ticks
	logic [14:0] ord_all; // All five order slots
	logic [2:0] ord_sel; // Column of current slot
	logic [NCOL-1:0] scan_pat; // Drive pattern while scanning
	logic hit_now; // Checked row reads low

	always_comb begin
		// Out of range sizes fall back to the full matrix
		ncol_m1 = (szc_r > 3'(NCOL - 1)) ? 3'(NCOL - 1) : szc_r;
		nrow_m1 = (szr_r > 3'(NROWS - 1)) ? 3'(NROWS - 1) : szr_r;
		rmask = '0;
		for (int i = 0; i < NROWS; i++) begin
			rmask[i] = (3'(i) <= nrow_m1);
		end
		any_low = |(~row_sense_n & rmask);
		// Field value n gives (n+1) steps
		db_ticks = 11'((time_r[DBT_LSB +: 8] + 10'd1) * DB_STEP);
		rc_ticks = 11'((time_r[RCI_LSB +: 2] + 10'd1) * RC_STEP);
		ord_all = {ordh_r, ordl_r};
		ord_sel = ord_all[ORD_W * slot_r +: ORD_W];
		// A slot naming no real column drives nothing low
		scan_pat = '1;
		for (int c = 0; c < NCOL; c++) begin
			if (ord_sel == 3'(c)) begin
				scan_pat[c] = 1'b0;
			end
		end
		hit_now = ~row_sense_n[rowi_r];
	end

	// ************************************************************
	// Avalon-MM slave: one wait state on every access
	// ************************************************************
	assign wr_go = avs_write && !avs_waitrequest;
	assign wstb_col = wr_go && avs_address == OFS_COL && avs_byteenable[0];

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (avs_address)
			OFS_MCLK: rdata_nxt[KCE_BIT] = kce_r;
			OFS_STAT: begin
				rdata_nxt[SEN_BIT] = sen_r;
				rdata_nxt[BSY_BIT] = (st_r != KMS_IDLE);
				rdata_nxt[MLT_BIT] = mlt_r;
			end
			OFS_SIZE: begin
				rdata_nxt[SZC_LSB +: 3] = szc_r;
				rdata_nxt[SZR_LSB +: 3] = szr_r;
			end
			OFS_TIME: rdata_nxt[9:0] = time_r;
			OFS_ORDL: rdata_nxt[ORDL_W-1:0] = ordl_r;
			OFS_ORDH: rdata_nxt[ORDH_W-1:0] = ordh_r;
			OFS_COL: rdata_nxt[NCOL-1:0] = col_r;
			// Bypass shows live rows, auto mode the stored result
			OFS_ROW: rdata_nxt[NROWS-1:0] = sen_r ? row_r : row_sense_n;
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Waitrequest drops for one cycle per request
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
		end
	end

	// Read data is latched with the waitrequest drop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rdata_nxt;
		end
	end

	// Control registers, honouring byte lanes 0 and 1
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			kce_r <= 1'b0;
			sen_r <= 1'b0;
			szc_r <= 3'(NCOL - 1);
			szr_r <= 3'(NROWS - 1);
			time_r <= TIME_RST;
			ordl_r <= ORDL_RST;
			ordh_r <= ORDH_RST;
		end else if (wr_go) begin
			case (avs_address)
				OFS_MCLK: if (avs_byteenable[0]) begin
					kce_r <= avs_writedata[KCE_BIT];
				end
				OFS_STAT: if (avs_byteenable[0]) begin
					sen_r <= avs_writedata[SEN_BIT];
				end
				OFS_SIZE: if (avs_byteenable[0]) begin
					szc_r <= avs_writedata[SZC_LSB +: 3];
					szr_r <= avs_writedata[SZR_LSB +: 3];
				end
				OFS_TIME: begin
					if (avs_byteenable[0]) begin
						time_r[7:0] <= avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						time_r[9:8] <= avs_writedata[9:8];
					end
				end
				// Order is read live; firmware rewrites it to change
				OFS_ORDL: if (avs_byteenable[0]) begin
					ordl_r <= avs_writedata[ORDL_W-1:0];
				end
				OFS_ORDH: begin
					if (avs_byteenable[0]) begin
						ordh_r[7:0] <= avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						ordh_r[8] <= avs_writedata[8];
					end
				end
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Keypad tick divider
	// ************************************************************
	// Stands still while the keypad clock is off, saving toggles
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else if (!kce_r) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else if (div_r == DW'(DIV - 1)) begin
			div_r <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	// ************************************************************
	// Scan sequencer
	// ************************************************************
	// Moves on ticks, or to idle on disable; never waits for firmware
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= KMS_IDLE;
			ivl_r <= '0;
			slot_r <= '0;
			rowi_r <= '0;
			hits_r <= '0;
			cpat_r <= COL_RST;
			rpat_r <= '1;
		end else if (!sen_r) begin
			st_r <= KMS_IDLE;
			ivl_r <= '0;
		end else if (tick_r) begin
			case (st_r)
				KMS_IDLE: begin
					ivl_r <= '0;
					if (any_low) begin
						st_r <= KMS_DEB_PRESS;
					end
				end
				KMS_DEB_PRESS: begin
					if (ivl_r + 10'd1 >= db_ticks) begin
						ivl_r <= '0;
						slot_r <= '0;
						rowi_r <= '0;
						hits_r <= '0;
						// Recheck the low before scanning
						st_r <= any_low ? KMS_SCAN : KMS_IDLE;
					end else begin
						ivl_r <= ivl_r + 10'd1;
					end
				end
				KMS_SCAN: begin
					if (ivl_r + 10'd1 >= rc_ticks) begin
						ivl_r <= '0;
						if (hit_now && hits_r != 2'd2) begin
							hits_r <= hits_r + 2'd1;
						end
						if (hit_now && hits_r == 2'd0) begin
							cpat_r <= scan_pat;
							rpat_r <= ~(NROWS'(1) << rowi_r);
						end
						if (rowi_r == nrow_m1) begin
							rowi_r <= '0;
							if (slot_r == ncol_m1) begin
								st_r <= KMS_WAIT_REL;
							end else begin
								slot_r <= slot_r + 3'd1;
							end
						end else begin
							rowi_r <= rowi_r + 3'd1;
						end
					end else begin
						ivl_r <= ivl_r + 10'd1;
					end
				end
				KMS_WAIT_REL: begin
					ivl_r <= '0;
					if (!any_low) begin
						st_r <= KMS_DEB_REL;
					end
				end
				KMS_DEB_REL: begin
					if (any_low) begin
						ivl_r <= '0;
					end else if (ivl_r + 10'd1 >= db_ticks) begin
						ivl_r <= '0;
						st_r <= KMS_IDLE;
					end else begin
						ivl_r <= ivl_r + 10'd1;
					end
				end
				default: st_r <= KMS_IDLE;
			endcase
		end
	end

	// Scan ends on this tick; result counts this last check too
	logic scan_end;
	logic [1:0] hits_fin;
	assign scan_end = sen_r && tick_r && st_r == KMS_SCAN &&
		ivl_r + 10'd1 >= rc_ticks && rowi_r == nrow_m1 &&
		slot_r == ncol_m1;
	assign hits_fin = (hit_now && hits_r != 2'd2) ? hits_r + 2'd1 : hits_r;
	// ************************************************************
	// Result registers and key event
	// ************************************************************
	// In auto mode only a single key may touch the results
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			col_r <= COL_RST;
			row_r <= '1;
			mlt_r <= 1'b0;
			key_irq <= 1'b0;
		end else begin
			key_irq <= 1'b0;
			if (scan_end) begin
				mlt_r <= (hits_fin == 2'd2);
				if (hits_fin == 2'd1) begin
					key_irq <= 1'b1;
					col_r <= (hits_r == 2'd0) ? scan_pat : cpat_r;
					row_r <= (hits_r == 2'd0) ?
						~(NROWS'(1) << rowi_r) : rpat_r;
				end
			end else if (wstb_col && !sen_r) begin
				col_r <= avs_writedata[NCOL-1:0];
			end
		end
	end
	// ************************************************************
	// Column drive
	// ************************************************************
	// Registered so the pins never glitch on a state change
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			col_drive_n <= COL_RST;
		end else if (!sen_r) begin
			col_drive_n <= col_r;
		end else if (st_r == KMS_SCAN) begin
			col_drive_n <= scan_pat;
		end else begin
			col_drive_n <= '0;
		end
	end
endmodule

`default_nettype wire

// >>> logic/kms_pkg.sv
// Package of constants for the keypad matrix scanner
package kms_pkg;
	// ************************************************************
	// Register byte offsets (Avalon word aligned)
	// ************************************************************
	localparam logic [5:0] OFS_MCLK = 6'h00; // Master clock control
	localparam logic [5:0] OFS_STAT = 6'h04; // Keypad status
	localparam logic [5:0] OFS_SIZE = 6'h08; // Keypad size setting
	localparam logic [5:0] OFS_TIME = 6'h0C; // Scan timing
	localparam logic [5:0] OFS_ORDL = 6'h10; // Column order low
	localparam logic [5:0] OFS_ORDH = 6'h14; // Column order high
	localparam logic [5:0] OFS_COL = 6'h18; // Column result
	localparam logic [5:0] OFS_ROW = 6'h1C; // Row result

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int KCE_BIT = 6; // Keypad clock enable
	localparam int SEN_BIT = 0; // Auto scan enable
	localparam int BSY_BIT = 1; // Scanner busy, read only
	localparam int MLT_BIT = 2; // Last scan saw several keys
	localparam int SZC_LSB = 0; // Active columns minus one
	localparam int SZR_LSB = 4; // Active rows minus one
	localparam int DBT_LSB = 0; // Debounce field, 8 bits
	localparam int RCI_LSB = 8; // Row check field, 2 bits
	localparam int ORD_W = 3; // Width of one order slot
	localparam int ORDL_W = 6; // Slots 0 and 1
	localparam int ORDH_W = 9; // Slots 2, 3 and 4

	// ************************************************************
	// Widths, reset values, timing
	// ************************************************************
	localparam int NCOL = 5; // Column drive lines
	localparam logic [5:0] ORDL_RST = 6'h08; // Slots 0,1
	localparam logic [8:0] ORDH_RST = 9'h0E2; // Slots 2,3,4
	localparam logic [4:0] COL_RST = 5'h1F; // Nothing driven low
	localparam logic [9:0] TIME_RST = 10'h000;
	localparam int CLK_HZ = 20_000_000; // Mclk rate
	localparam int TICK_HZ = 1_000; // Keypad tick rate
	localparam int TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int TICK_MS = 1; // Tick period in ms
	localparam int DB_STEP_MS = 4; // Debounce step
	localparam int DB_STEP = DB_STEP_MS / TICK_MS; // In ticks
	localparam int RC_STEP_MS = 1; // Row check step
	localparam int RC_STEP = RC_STEP_MS / TICK_MS; // In ticks

	// Scanner states
	typedef enum logic [2:0] {
		KMS_IDLE,
		KMS_DEB_PRESS,
		KMS_SCAN,
		KMS_WAIT_REL,
		KMS_DEB_REL
	} kms_state_t;
endpackage

// >>> logic/kms_dummy_unused.sv
// Intentionally empty companion file
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> test/kms_scanner_sva.sv
// Checker for the keypad matrix scanner port behaviour
`timescale 1ns/10ps
`default_nettype none
module kms_scanner_chk
	import kms_pkg::*;
#(
	parameter int NROWS = 6,
	parameter int DIV = TICK_DIV
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [NCOL-1:0] col_drive_n,
	input wire logic [NROWS-1:0] row_sense_n,
	input wire logic key_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ****
	// Shadows
	// ****
	logic wtk; // A write lands at this edge
	logic sen_r; // Scan enable as last written
	logic cke_r; // Clock enable as last written
	logic [1:0] quiet_r; // Bypass cycles with no column write
	int low_r; // Cycles some row has been low
	assign wtk = avs_write && !avs_waitrequest;
	// Enables are followed from the bus, the core is not visible
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sen_r <= 1'b0;
			cke_r <= 1'b0;
		end else if (wtk && avs_address == OFS_STAT) begin
			sen_r <= avs_writedata[SEN_BIT];
		end else if (wtk && avs_address == OFS_MCLK) begin
			cke_r <= avs_writedata[KCE_BIT];
		end
	end
	// Saturates so a long bypass stays checked
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			quiet_r <= 2'h0;
		end else if (sen_r || (wtk && avs_address == OFS_COL)) begin
			quiet_r <= 2'h0;
		end else if (quiet_r != 2'h3) begin
			quiet_r <= quiet_r + 2'h1;
		end
	end
	// Capped so the count never wraps in a long hold
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			low_r <= 0;
		end else if (&row_sense_n) begin
			low_r <= 0;
		end else if (low_r < 100000) begin
			low_r <= low_r + 1;
		end
	end
	// ****
	// Properties
	// ****
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_bus_answer: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer to bus request");
	a_one_col_low: assert property (sen_r && $past(sen_r) |->
		col_drive_n == 5'h00 || $onehot(~col_drive_n) || col_drive_n == 5'h1F)
		else $error("several columns driven low");
	a_irq_pulse: assert property (key_irq |=> !key_irq)
		else $error("key pulse longer than one cycle");
	a_irq_scan_on: assert property (key_irq |-> sen_r && cke_r)
		else $error("key reported without scanning");
	a_release_cols: assert property (key_irq |-> ##[0:2]
		col_drive_n == 5'h00) else $error("columns not all low after a key");
	a_bypass_stable: assert property (quiet_r == 2'h3 |->
		$stable(col_drive_n)) else $error("column drives moved in bypass");
	a_frozen_noclk: assert property ((!cke_r && sen_r) [*4]
		|-> $stable(col_drive_n)) else $error("scan moved with no tick");
	a_debounce_min: assert property (sen_r && $past(sen_r) &&
		$past(col_drive_n) == 5'h00 && col_drive_n != 5'h00 |-> low_r >= 3 * DIV)
		else $error("scan began before debounce");
	c_key: cover property (key_irq);
	c_bypass: cover property (quiet_r == 2'h3 && col_drive_n != 5'h1F);
	c_frozen: cover property (!cke_r && sen_r && !(&row_sense_n));
endmodule
bind kms_scanner kms_scanner_chk #(.NROWS(NROWS), .DIV(DIV)) chk_u (
	.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .col_drive_n(col_drive_n),
	.row_sense_n(row_sense_n), .key_irq(key_irq)
);
`default_nettype wire

// >>> test/kms_keymatrix.sv
// Passive key switch matrix with pull-ups on the rows
`timescale 1ns/10ps
`default_nettype none
module kms_keymatrix #(
	parameter int NROWS = 6
) (
	input wire logic [4:0] col_drive_n,
	input wire logic [2:0] ka_c,
	input wire logic [2:0] ka_r,
	input wire logic [2:0] kb_c,
	input wire logic [2:0] kb_r,
	output logic [NROWS-1:0] row_sense_n
);
	// Pull-ups hold a row high unless a closed key meets a low column
	always_comb begin
		row_sense_n = '1;
		for (int r = 0; r < NROWS; r++) begin
			if (ka_r == r && ka_c < 5 && !col_drive_n[ka_c]) begin
				row_sense_n[r] = 1'b0;
			end
			if (kb_r == r && kb_c < 5 && !col_drive_n[kb_c]) begin
				row_sense_n[r] = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the keypad matrix scanner
`timescale 1ns/10ps
`default_nettype none
module tb
	import kms_pkg::*;
;
	logic mclk, rst, rd, wr, wreq, irq, hit;
	logic [5:0] addr, rows;
	logic [31:0] wd, rdat, q;
	logic [4:0] col;
	logic [2:0] ka_c, ka_r, kb_c, kb_r; // Closed keys, 7 means open
	int n_fail, total_checks, i;
	// Tick every 4 clocks keeps scans short
	kms_scanner #(.NROWS(6), .DIV(4)) dut_u (.mclk(mclk), .rst(rst),
		.avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .col_drive_n(col), .row_sense_n(rows),
		.key_irq(irq));
	kms_keymatrix #(.NROWS(6)) key_u (.col_drive_n(col), .ka_c(ka_c),
		.ka_r(ka_r), .kb_c(kb_c), .kb_r(kb_r), .row_sense_n(rows));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ****
	// Shared tasks
	// ****
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Holds the request until waitrequest is seen low at an edge
	task bus(input logic [5:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge mclk);
		addr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		n = 0;
		// Waitrequest and read data are sampled at rising edges only
		do begin
			@(posedge mclk);
			n++;
		end while (wreq !== 1'b0 && n < 100);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wreq !== 1'b0) n_fail++;
	endtask
	task rg(input logic [5:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task key(input logic [2:0] c, input logic [2:0] r);
		@(posedge mclk);
		ka_c <= c;
		ka_r <= r;
	endtask
	// Waits a bounded span for the key pulse, judges its presence
	task wirq(input int n, input logic e);
		hit = 1'b0;
		for (i = 0; i < n && !hit; i++) begin
			@(negedge mclk);
			if (irq === 1'b1) hit = 1'b1;
		end
		chk(32'(hit), 32'(e));
	endtask
	task scan_start;
		for (i = 0; i < 400 && col === 5'h00; i++) @(negedge mclk);
	endtask
	task done(input string s);
		$display("test %s finished, fails %0d", s, n_fail);
	endtask
	task final_report;
		$display("checks %0d, fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task t_regs;
		rg(OFS_STAT, 32'h0);
		rg(OFS_SIZE, 32'h54);
		rg(OFS_TIME, 32'h0);
		rg(OFS_ORDL, 32'h8);
		rg(OFS_ORDH, 32'hE2);
		rg(OFS_COL, 32'h1F);
		rg(OFS_ROW, 32'h3F);
		bus(6'h20, 1'b1, 32'hFFFF);
		rg(6'h20, 32'h0);
		bus(OFS_STAT, 1'b1, 32'h6);
		rg(OFS_STAT, 32'h0);
		done("regs");
	endtask
	// Firmware drives one column and reads the rows by hand
	task t_bypass;
		bus(OFS_COL, 1'b1, 32'h1E);
		key(3'h0, 3'h2);
		repeat (3) @(posedge mclk);
		chk(32'(col), 32'h1E);
		rg(OFS_ROW, 32'h3B);
		key(3'h7, 3'h7);
		done("bypass");
	endtask
	task t_single;
		bus(OFS_MCLK, 1'b1, 32'h40);
		bus(OFS_STAT, 1'b1, 32'h1);
		repeat (3) @(posedge mclk);
		chk(32'(col), 32'h0);
		key(3'h2, 3'h3);
		wirq(400, 1'b1);
		rg(OFS_COL, 32'h1B);
		rg(OFS_ROW, 32'h37);
		key(3'h7, 3'h7);
		repeat (100) @(posedge mclk);
		rg(OFS_STAT, 32'h1);
		chk(32'(col), 32'h0);
		done("single");
	endtask
	// Two keys: nothing reported, old result kept
	task t_multi;
		@(posedge mclk);
		kb_c <= 3'h3;
		kb_r <= 3'h4;
		key(3'h1, 3'h0);
		wirq(400, 1'b0);
		key(3'h7, 3'h7);
		@(posedge mclk);
		kb_c <= 3'h7;
		repeat (100) @(posedge mclk);
		rg(OFS_STAT, 32'h5);
		rg(OFS_COL, 32'h1B);
		done("multi");
	endtask
	task t_short;
		key(3'h0, 3'h1);
		repeat (8) @(posedge mclk);
		key(3'h7, 3'h7);
		wirq(200, 1'b0);
		chk(32'(col), 32'h0);
		done("short");
	endtask
	// Reversed column order: column 4 is driven first
	task t_order;
		bus(OFS_ORDL, 1'b1, 32'h1C);
		bus(OFS_ORDH, 1'b1, 32'hA);
		key(3'h0, 3'h1);
		scan_start;
		chk(32'(col), 32'hF);
		wirq(400, 1'b1);
		rg(OFS_COL, 32'h1E);
		rg(OFS_ROW, 32'h3D);
		key(3'h7, 3'h7);
		repeat (100) @(posedge mclk);
		done("order");
	endtask
	task t_noclk;
		bus(OFS_MCLK, 1'b1, 32'h0);
		key(3'h4, 3'h5);
		wirq(300, 1'b0);
		bus(OFS_MCLK, 1'b1, 32'h40);
		wirq(400, 1'b1);
		rg(OFS_COL, 32'hF);
		rg(OFS_ROW, 32'h1F);
		key(3'h7, 3'h7);
		repeat (100) @(posedge mclk);
		done("noclk");
	endtask
	// Scan stopped part way: drives fall back to the column result
	task t_midoff;
		key(3'h0, 3'h1);
		scan_start;
		bus(OFS_STAT, 1'b1, 32'h0);
		repeat (4) @(posedge mclk);
		chk(32'(col), 32'hF);
		rg(OFS_COL, 32'hF);
		key(3'h7, 3'h7);
		done("midoff");
	endtask
	// Two columns, three rows, longer intervals; order still reversed
	task t_size;
		bus(OFS_SIZE, 1'b1, 32'h21);
		bus(OFS_TIME, 1'b1, 32'h101);
		bus(OFS_STAT, 1'b1, 32'h1);
		key(3'h0, 3'h5);
		wirq(200, 1'b0);
		chk(32'(col), 32'h0);
		key(3'h0, 3'h1);
		wirq(300, 1'b0);
		key(3'h7, 3'h7);
		repeat (100) @(posedge mclk);
		key(3'h3, 3'h1);
		wirq(400, 1'b1);
		rg(OFS_COL, 32'h17);
		rg(OFS_ROW, 32'h3D);
		key(3'h7, 3'h7);
		repeat (100) @(posedge mclk);
		rg(OFS_STAT, 32'h1);
		rg(OFS_TIME, 32'h101);
		done("size");
	endtask
	initial begin
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 6'h0;
		wd = 32'h0;
		ka_c = 3'h7;
		ka_r = 3'h7;
		kb_c = 3'h7;
		kb_r = 3'h7;
		n_fail = 0;
		total_checks = 0;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		t_regs;
		t_bypass;
		t_single;
		t_multi;
		t_short;
		t_order;
		t_noclk;
		t_midoff;
		t_size;
		final_report;
	end
	// Whole run needs a few thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		final_report;
	end
endmodule
`default_nettype wire
